// ==== logic/qr_ctrl_pkg.sv ====
// Constants and carrier types of the quasi-resonant valley-skip controller.
// Function
// R1 - Supply above turn-on threshold: release charging path, start switching with soft-start.
// R2 - Soft-start is digital, 12 ms total, four equal steps.
// R3 - Sense limit steps from 0.32 V at first step to 1 V.
// R4 - Switch-on from valley events and counter; switch-off from analog compare.
// R5 - Up/down counter holds number of valleys skipped before switch-on.
// R6 - Feedback compared and counter updated once every 48 ms period.
// R7 - Feedback always below low zone: counter up by one, stops at 7.
// R8 - Above low zone but never high zone: counter unchanged.
// R9 - Above high zone but never reset threshold: counter down, stops at 1.
// R10 - Feedback above reset threshold forces counter to 1 at once.
// R11 - Counter stays within 1 to 7; out-of-range steps ignored.
// R12 - Counter loaded with 1 at start-up.
// R13 - Zone thresholds chosen by detected line voltage level.
// R14 - Ringing suppression timer blocks false switch-on after turn-off.
// R15 - Valley counter 0 to 7 counts falling crossings, clears on gate high.
// R16 - After suppression, gate on when valley count reaches up/down counter.
// R17 - Gate forced on after maximum off interval.
// R18 - Threshold flags synchronised, latched per period, cleared at period start.
// R19 - Soft-start step output as two-bit code, holds final step.
package qr_ctrl_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int SOFTSTART_MS = 12;
    localparam int SOFTSTART_STEPS = 4;
    localparam int EVAL_PERIOD_MS = 48;
    localparam int RING_LONG_US = 5;
    localparam int RING_SHORT_US = 2;
    localparam int MAX_OFF_US = 50;
    localparam int STEP_CYCLES = (CLK_HZ / 1000) * SOFTSTART_MS / SOFTSTART_STEPS;
    localparam int EVAL_CYCLES = (CLK_HZ / 1000) * EVAL_PERIOD_MS;
    localparam int RING_LONG_CYCLES = (CLK_HZ / 1_000_000) * RING_LONG_US;
    localparam int RING_SHORT_CYCLES = (CLK_HZ / 1_000_000) * RING_SHORT_US;
    localparam int MAX_OFF_CYCLES = (CLK_HZ / 1_000_000) * MAX_OFF_US;
    localparam logic [2:0] SKIP_MIN = 3'h1;
    localparam logic [2:0] SKIP_MAX = 3'h7;
    localparam logic [2:0] SKIP_RESET = 3'h1;
    localparam logic [2:0] VALLEY_MAX = 3'h7;
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_FINAL = 2'h3;

    typedef enum logic [1:0] {
        ST_CHARGE = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b11
    } phase_type;

    // Comparator flags from the analog side, all asynchronous.
    typedef struct packed {
        logic supply_on;
        logic fb_low_zone;
        logic fb_high_zone;
        logic fb_counter_reset;
        logic valley_detect;
        logic ring_level_high;
        logic sense_trip;
        logic line_high;
    } analog_in_type;

    typedef struct packed {
        logic gate_drive;
        logic startup_charge_en;
        logic [1:0] softstart_step;
        logic [2:0] skip_count;
        logic line_high_sel;
    } ctrl_out_type;

endpackage

// ==== logic/period_timer.sv ====
// Free counter that emits a one-cycle tick every PERIOD cycles while enabled.
`timescale 1ns/100ps
module period_timer #(
    parameter int PERIOD = 100
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);
    localparam int W = $clog2(PERIOD + 1);

    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } timer_type;

    timer_type state_q;
    timer_type state_d;

    always_comb
    begin
        state_d = state_q;
        state_d.tick = 1'b0;
        if (!run)
        begin
            state_d.count = '0;
        end
        else if (state_q.count == W'(PERIOD - 1))
        begin
            state_d.count = '0;
            state_d.tick = 1'b1;
        end
        else
        begin
            state_d.count = state_q.count + W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign tick = state_q.tick;
endmodule

// ==== logic/qr_valley_skip_softstart_ctrl.sv ====
// Start-up sequencing, soft-start and valley-skip switch-on control.
`timescale 1ns/100ps
module qr_valley_skip_softstart_ctrl #(
    parameter int STEP_CYCLES = qr_ctrl_pkg::STEP_CYCLES,
    parameter int EVAL_CYCLES = qr_ctrl_pkg::EVAL_CYCLES,
    parameter int RING_LONG_CYCLES = qr_ctrl_pkg::RING_LONG_CYCLES,
    parameter int RING_SHORT_CYCLES = qr_ctrl_pkg::RING_SHORT_CYCLES,
    parameter int MAX_OFF_CYCLES = qr_ctrl_pkg::MAX_OFF_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input qr_ctrl_pkg::analog_in_type analog_in,
    output qr_ctrl_pkg::ctrl_out_type ctrl_out
);
    localparam int OFF_W = $clog2(MAX_OFF_CYCLES + 1);
    localparam int RING_W = $clog2(RING_LONG_CYCLES + RING_SHORT_CYCLES + 1);

    typedef struct packed {
        qr_ctrl_pkg::analog_in_type sync1;
        qr_ctrl_pkg::analog_in_type sync2;
        logic valley_prev;
        qr_ctrl_pkg::phase_type phase;
        logic [1:0] step;
        logic seen_low;
        logic seen_high;
        logic eval_run;
        logic [2:0] skip;
        logic [2:0] valleys;
        logic gate;
        logic [RING_W-1:0] ring;
        logic [OFF_W-1:0] off_count;
        qr_ctrl_pkg::ctrl_out_type out;
    } ctrl_state_type;

    ctrl_state_type state_q;
    ctrl_state_type state_d;
    logic step_tick;
    logic eval_tick;

    period_timer #(.PERIOD(STEP_CYCLES)) step_timer (
        .clk(clk),
        .rst(rst),
        .run(state_q.phase == qr_ctrl_pkg::ST_SOFT),
        .tick(step_tick)
    );

    // R6 - fixed evaluation period
    period_timer #(.PERIOD(EVAL_CYCLES)) eval_timer (
        .clk(clk),
        .rst(rst),
        .run(state_q.eval_run),
        .tick(eval_tick)
    );

    always_comb
    begin
        state_d = state_q;
        state_d.sync1 = analog_in;
        // R18 - two-stage synchronisers
        state_d.sync2 = state_q.sync1;
        // A third stage keeps the last synchronised valley level for edge detection.
        state_d.valley_prev = state_q.sync2.valley_detect;

        case (state_q.phase)
            qr_ctrl_pkg::ST_CHARGE:
            begin
                // R1 - turn-on threshold crossed
                if (state_q.sync2.supply_on)
                begin
                    state_d.phase = qr_ctrl_pkg::ST_SOFT;
                    state_d.step = qr_ctrl_pkg::STEP_FIRST;
                    state_d.eval_run = 1'b1;
                    state_d.off_count = '0;
                end
            end
            qr_ctrl_pkg::ST_SOFT:
            begin
                // R2 - four timed steps
                if (step_tick)
                begin
                    if (state_q.step == qr_ctrl_pkg::STEP_FINAL)
                    begin
                        state_d.phase = qr_ctrl_pkg::ST_RUN;
                    end
                    else
                    begin
                        state_d.step = state_q.step + 2'h1;
                    end
                end
            end
            qr_ctrl_pkg::ST_RUN:
            begin
                // R19 - hold final step
                state_d.step = qr_ctrl_pkg::STEP_FINAL;
            end
            default:
            begin
                state_d.phase = qr_ctrl_pkg::ST_CHARGE;
            end
        endcase

        // R18 - period flags, new period starts clean
        // The level seen on the tick opens the new period, so no sample is lost.
        if (eval_tick)
        begin
            state_d.seen_low = state_q.sync2.fb_low_zone;
            state_d.seen_high = state_q.sync2.fb_high_zone;
        end
        else
        begin
            state_d.seen_low = state_q.seen_low | state_q.sync2.fb_low_zone;
            state_d.seen_high = state_q.seen_high | state_q.sync2.fb_high_zone;
        end

        // The reset threshold outranks the periodic update, even on a tick.
        // R10 - immediate reset to one
        if (state_q.sync2.fb_counter_reset)
        begin
            state_d.skip = qr_ctrl_pkg::SKIP_RESET;
        end
        else if (eval_tick)
        begin
            // R7 R11 - count up, saturating
            if (!state_q.seen_low)
            begin
                if (state_q.skip != qr_ctrl_pkg::SKIP_MAX)
                begin
                    state_d.skip = state_q.skip + 3'h1;
                end
            end
            // R9 R11 - count down, saturating
            else if (state_q.seen_high)
            begin
                if (state_q.skip != qr_ctrl_pkg::SKIP_MIN)
                begin
                    state_d.skip = state_q.skip - 3'h1;
                end
            end
            // R8 - otherwise hold
        end

        if (state_q.phase != qr_ctrl_pkg::ST_CHARGE)
        begin
            if (state_q.gate)
            begin
                // Blanking of the trip comparator is left to the analog side.
                // R4 - analog compare ends the on-time
                if (state_q.sync2.sense_trip)
                begin
                    state_d.gate = 1'b0;
                    state_d.off_count = '0;
                    // R14 - suppression length follows ringing level
                    state_d.ring = state_q.sync2.ring_level_high ?
                        RING_W'(RING_SHORT_CYCLES) : RING_W'(RING_LONG_CYCLES);
                end
            end
            else
            begin
                if (state_q.ring != '0)
                begin
                    state_d.ring = state_q.ring - RING_W'(1);
                end
                if (state_q.off_count != OFF_W'(MAX_OFF_CYCLES))
                begin
                    state_d.off_count = state_q.off_count + OFF_W'(1);
                end
                // R15 - count falling crossings
                if (state_q.valley_prev && !state_q.sync2.valley_detect
                    && state_q.valleys != qr_ctrl_pkg::VALLEY_MAX)
                begin
                    state_d.valleys = state_q.valleys + 3'h1;
                end
                // The off counter saturates at the cap, which then forces the gate on.
                // R17 - maximum off interval
                if (state_q.off_count == OFF_W'(MAX_OFF_CYCLES))
                begin
                    state_d.gate = 1'b1;
                end
                // R16 R5 - enough valleys skipped
                else if (state_q.ring == '0 && state_q.valleys >= state_q.skip)
                begin
                    state_d.gate = 1'b1;
                end
                // R15 - clear on gate high
                if (state_d.gate)
                begin
                    state_d.valleys = '0;
                end
            end
        end

        state_d.out.gate_drive = state_d.gate;
        // R1 - charging path off once operating
        state_d.out.startup_charge_en = (state_d.phase == qr_ctrl_pkg::ST_CHARGE);
        // R3 R19 - limit level code
        state_d.out.softstart_step = state_d.step;
        state_d.out.skip_count = state_d.skip;
        // R13 - zone threshold set by line level
        state_d.out.line_high_sel = state_q.sync2.line_high;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Outputs leave reset idle: gate low, charging path on, counter at one.
            state_q <= '0;
            state_q.phase <= qr_ctrl_pkg::ST_CHARGE;
            // R12 - start at one
            state_q.skip <= qr_ctrl_pkg::SKIP_RESET;
            state_q.out.skip_count <= qr_ctrl_pkg::SKIP_RESET;
            state_q.out.startup_charge_en <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign ctrl_out = state_q.out;
endmodule

// ==== verification/qr_ctrl_sva.sv ====
// Port-level assertions for the valley-skip controller.
`timescale 1ns/100ps
module qr_ctrl_sva #(
    parameter int MAX_OFF_CYCLES = 60
)
(
    input wire logic clk,
    input wire logic rst,
    input qr_ctrl_pkg::analog_in_type analog_in,
    input qr_ctrl_pkg::ctrl_out_type ctrl_out
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    int off_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            off_q <= 0;
        end
        else if (ctrl_out.gate_drive || ctrl_out.startup_charge_en)
        begin
            off_q <= 0;
        end
        else
        begin
            off_q <= off_q + 1;
        end
    end
    a_skip_in_range: assert property (ctrl_out.skip_count inside {[3'h1:3'h7]})
        else $error("skip count out of range");
    a_skip_single_step: assert property ($changed(ctrl_out.skip_count) |->
        ctrl_out.skip_count == 3'h1 || ctrl_out.skip_count == $past(ctrl_out.skip_count) + 3'h1
        || ctrl_out.skip_count + 3'h1 == $past(ctrl_out.skip_count))
        else $error("skip count jumped");
    a_reset_forces_one: assert property (analog_in.fb_counter_reset [*5] |->
        ctrl_out.skip_count == 3'h1) else $error("skip not forced to one");
    a_charge_path_off: assert property (analog_in.supply_on [*5] |->
        !ctrl_out.startup_charge_en) else $error("charge path still on");
    a_gate_after_charge: assert property (ctrl_out.startup_charge_en |->
        !ctrl_out.gate_drive) else $error("gate on while charging");
    a_step_no_fall: assert property (ctrl_out.softstart_step >=
        $past(ctrl_out.softstart_step)) else $error("soft-start step fell");
    a_step_final_hold: assert property (ctrl_out.softstart_step == 2'h3 |=>
        ctrl_out.softstart_step == 2'h3) else $error("final step left");
    a_ring_block: assert property ($fell(ctrl_out.gate_drive) |->
        !ctrl_out.gate_drive [*2]) else $error("gate on during suppression");
    a_max_off_cap: assert property (off_q <= MAX_OFF_CYCLES + 3)
        else $error("gate off too long");
    a_start_skip_one: assert property ($fell(rst) |-> ctrl_out.skip_count == 3'h1)
        else $error("skip not one after start");
    c_skip_top: cover property (ctrl_out.skip_count == 3'h7);
    c_gate_rise: cover property ($rose(ctrl_out.gate_drive));
    c_step_final: cover property (ctrl_out.softstart_step == 2'h3);
endmodule

// ==== verification/analog_side_model.sv ====
// Far-side model: ringing valley comparator and switch-off comparator.
`timescale 1ns/100ps
module analog_side_model #(
    parameter int ON_CYCLES = 4,
    parameter int HALF_RING = 3
)
(
    input wire logic clk,
    input wire logic gate_drive,
    input wire logic ringing,
    output logic valley_detect,
    output logic sense_trip
);
    int t = 0;
    int t_now;
    logic g_q = 1'b0;
    // Cycles since the last gate edge, zero on the first falling clock after that edge.
    assign t_now = (gate_drive != g_q) ? 0 : t + 1;
    always @(negedge clk)
    begin
        g_q <= gate_drive;
        t <= t_now;
        sense_trip <= gate_drive && t_now >= ON_CYCLES;
        valley_detect <= !gate_drive && ringing && (t_now / HALF_RING) % 2 == 1;
    end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the valley-skip soft-start controller.
`timescale 1ns/100ps
module testbench;
    localparam int STEP = 50;
    localparam int EVAL = 400;
    localparam int MAXOFF = 60;
    logic clk, rst, sup, fl, fh, fr, rh, lh, ringing, vd, trip;
    qr_ctrl_pkg::analog_in_type ain;
    qr_ctrl_pkg::ctrl_out_type co;
    int fails = 0;
    int n_checks = 0;
    int nv, len;
    assign ain = {sup, fl, fh, fr, vd, rh, trip, lh};
    qr_valley_skip_softstart_ctrl #(.STEP_CYCLES(STEP), .EVAL_CYCLES(EVAL),
        .RING_LONG_CYCLES(5), .RING_SHORT_CYCLES(2), .MAX_OFF_CYCLES(MAXOFF)) uut (
        .clk(clk), .rst(rst), .analog_in(ain), .ctrl_out(co));
    analog_side_model far (.clk(clk), .gate_drive(co.gate_drive), .ringing(ringing),
        .valley_detect(vd), .sense_trip(trip));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic step_skip(input logic [2:0] d, input int n);
        logic [2:0] old;
        logic [2:0] want;
        int k;
        repeat (n)
        begin
            old = co.skip_count;
            k = 0;
            while (co.skip_count === old && k < EVAL + 20)
            begin
                cyc(1);
                k++;
            end
            // one step per period, counted modulo eight.
            want = old + d;
            check(co.skip_count, want);
        end
    endtask
    task automatic off_phase();
        int k = 0;
        logic v_old;
        while (co.gate_drive !== 1'b1 && k < 5000)
        begin
            cyc(1);
            k++;
        end
        while (co.gate_drive !== 1'b0 && k < 5000)
        begin
            cyc(1);
            k++;
        end
        nv = 0;
        len = 0;
        v_old = vd;
        while (co.gate_drive !== 1'b1 && len < 5000)
        begin
            cyc(1);
            len++;
            if (v_old && !vd)
                nv++;
            v_old = vd;
        end
    endtask
    task automatic t_start();
        int k = 0;
        check(co, 8'h42);
        sup = 1'b1;
        while (co.startup_charge_en !== 1'b0 && k < 10)
        begin
            cyc(1);
            k++;
        end
        check(co.startup_charge_en, 1'b0);
        cyc(STEP / 2);
        for (int i = 0; i < 4; i++)
        begin
            check(co.softstart_step, i[1:0]);
            cyc(STEP);
        end
        cyc(3 * STEP);
        check(co.softstart_step, 2'h3);
    endtask
    task automatic t_line();
        lh = 1'b1;
        cyc(5);
        check(co.line_high_sel, 1'b1);
        lh = 1'b0;
        cyc(5);
        check(co.line_high_sel, 1'b0);
    endtask
    task automatic t_up_valleys();
        while (co.skip_count !== 3'h7 && fails < 20)
            step_skip(3'h1, 1);
        cyc(2 * EVAL);
        check(co.skip_count, 3'h7);
        repeat (2)
        begin
            off_phase();
            check(nv, 7);
        end
        ringing = 1'b0;
        off_phase();
        check(nv, 0);
        check(len >= MAXOFF && len <= MAXOFF + 3, 1'b1);
        ringing = 1'b1;
    endtask
    task automatic t_hold_down();
        fl = 1'b1;
        cyc(2 * EVAL);
        check(co.skip_count, 3'h7);
        fh = 1'b1;
        step_skip(3'h7, 6);
        cyc(2 * EVAL);
        check(co.skip_count, 3'h1);
        rh = 1'b1;
        off_phase();
        check(nv, 1);
        rh = 1'b0;
    endtask
    task automatic t_fast_reset();
        fl = 1'b0;
        fh = 1'b0;
        cyc(EVAL + 10);
        step_skip(3'h1, 2);
        fl = 1'b1;
        cyc(2 * EVAL);
        check(co.skip_count, 3'h3);
        {fh, fr} = 2'h3;
        cyc(6);
        check(co.skip_count, 3'h1);
        {fl, fh, fr} = 3'h0;
        cyc(EVAL + 10);
        // Lift the counter off one so that the mid-run reset has something to undo.
        step_skip(3'h1, 1);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        check(co, 8'h42);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        // About three times the nominal run of some 10,000 cycles.
        #300000;
        fails++;
        give_verdict();
    end
    initial
    begin
        {rst, sup, fl, fh, fr, rh, lh} = 7'h40;
        ringing = 1'b1;
        cyc(12);
        rst = 1'b0;
        cyc(1);
        t_start();
        t_line();
        t_up_valleys();
        t_hold_down();
        t_fast_reset();
        give_verdict();
    end
endmodule
bind qr_valley_skip_softstart_ctrl qr_ctrl_sva #(.MAX_OFF_CYCLES(MAX_OFF_CYCLES)) chk (
    .clk(clk), .rst(rst), .analog_in(analog_in), .ctrl_out(ctrl_out));
